// >>> rtl/cid_regs_pkg.sv
// Constants, types and register map of the caller-ID status and mode registers
package cid_regs_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_LINE_STATUS = 8'h02;
    localparam logic [7:0] ADDR_RING_PERIOD = 8'h03;
    localparam logic [7:0] ADDR_MODE_A = 8'h04;
    localparam logic [7:0] ADDR_MODE_B = 8'h05;
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;

    // line_status bit positions
    localparam int STA_POL_A = 7;
    localparam int STA_POL_B = 6;
    localparam int STA_LOW_BAT = 5;
    localparam int STA_MARK = 4;
    localparam int STA_OVERRUN = 3;
    localparam int STA_FRAMING = 2;

    // mode_control_a bit positions
    localparam int MDA_FSK_EN = 7;
    localparam int MDA_MARK_GATE = 6;
    localparam int MDA_ALERT_EN = 5;
    localparam int MDA_POL_IRQ_EN = 4;
    localparam int MDA_IRQ_HIGH = 3;

    // mode_control_b bit positions
    localparam int MDB_OSC_EN = 7;
    localparam int MDB_TB_EN = 6;
    localparam int MDB_TB_SECOND = 5;
    localparam int MDB_TB_SUPPRESS = 4;

    // Writable bits and values after reset
    localparam logic [7:0] MODE_A_MASK = 8'hF8;
    localparam logic [7:0] MODE_B_MASK = 8'hF0;
    localparam logic [7:0] MODE_A_RESET = 8'h58;
    localparam logic [7:0] MODE_B_RESET = 8'hD0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] RING_MAX = 8'hFF;

    // Timing
    localparam int unsigned SYS_CLK_HZ = 40_000_000;
    localparam int unsigned RING_TICK_MS = 32;
    localparam int unsigned RING_TICK_CYCLES =
        RING_TICK_MS * (SYS_CLK_HZ / 1000);

    // Register request carried from the serial engine
    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic [7:0] wdata;
    } reg_req_t;

    // Decoded mode controls driven to the rest of the receiver
    typedef struct packed {
        logic fsk_receiver_enable;
        logic mark_start_irq_gate;
        logic alert_detector_enable;
        logic polarity_irq_enable;
        logic irq_active_high;
        logic main_osc_enable;
        logic timebase_enable;
        logic timebase_period_select;
        logic timebase_irq_suppress;
    } mode_ctrl_t;

endpackage

// >>> rtl/cid_status_mode_regs.sv
// Status, ring period and mode registers of the caller-ID receiver
`timescale 1ns/1ps

// Functional notes
// - Bit 7 follows first polarity comparator
// - Bit 6 is second comparator, inverted
// - Bit 5 set while battery below reference
// - Bit 4 set after mark start detected
// - Bit 3 set on FSK overrun
// - Bit 2 set on FSK framing error
// - Ring period counts between first-comparator rises
// - Measurement valid only with second-comparator rise
// - Mode A bit 7 enables FSK receiver
// - Mode A bit 6 gates byte interrupts
// - Mode A bit 5 enables alert detector
// - Mode A bit 4 enables polarity interrupts
// - Mode A bit 3 picks interrupt level
// - Mode B bit 7 enables main oscillator
// - Mode B bit 6 enables timebase
// - Mode B bit 5 picks second/minute
// - Mode B bit 4 suppresses timebase during FSK
// - Status at 02H, read only
// - Suppressed timebase events still flagged
// - Unmapped reads FFH, bad writes ignored
module cid_status_mode_regs #(
    parameter int unsigned RING_TICK = cid_regs_pkg::RING_TICK_CYCLES
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Serial engine side, on the link clock
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic req_valid,
    input wire cid_regs_pkg::reg_req_t req,
    output logic req_ready_q,
    output logic rsp_valid_q,
    output logic [7:0] rd_data_q,
    // Comparator pins, asynchronous
    input wire logic polarity_input_a,
    input wire logic polarity_input_b,
    input wire logic low_battery_input,
    // Demodulator events, system clock
    input wire logic mark_start_event,
    input wire logic fsk_overrun_event,
    input wire logic fsk_framing_event,
    input wire logic fsk_receiving,
    // Mode controls and interrupt gating
    output cid_regs_pkg::mode_ctrl_t mode_q,
    output logic fsk_byte_irq_pass_q,
    output logic timebase_irq_pass_q
);
    import cid_regs_pkg::*;

    // Link domain request capture
    reg_req_t link_req_q;
    logic req_tgl_q;
    logic [2:0] ack_sync_q;
    logic ack_seen;
    logic [7:0] sys_rdata_q;
    logic ack_tgl_q;

    assign ack_seen = ack_sync_q[1] ^ ack_sync_q[2];

    // Request stays frozen while busy, so the system side may read it
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            link_req_q <= '0;
            req_tgl_q <= 1'b0;
            req_ready_q <= 1'b1;
        end
        else if (req_valid && req_ready_q)
        begin
            link_req_q <= req;
            req_tgl_q <= ~req_tgl_q;
            req_ready_q <= 1'b0;
        end
        else if (ack_seen)
        begin
            req_ready_q <= 1'b1;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            ack_sync_q <= 3'b000;
        end
        else
        begin
            ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            rsp_valid_q <= 1'b0;
            rd_data_q <= BYTE_ZERO;
        end
        else
        begin
            rsp_valid_q <= ack_seen;
            if (ack_seen)
            begin
                rd_data_q <= sys_rdata_q;
            end
        end
    end

    // System domain side of the request handshake
    logic [2:0] req_sync_q;
    logic req_seen;
    logic do_write;
    logic do_read;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            req_sync_q <= 3'b000;
        end
        else
        begin
            req_sync_q <= {req_sync_q[1:0], req_tgl_q};
        end
    end

    assign req_seen = req_sync_q[1] ^ req_sync_q[2];
    assign do_write = req_seen && link_req_q.write;
    assign do_read = req_seen && !link_req_q.write;

    // Comparator pin filters: three stages, change once the last two stages agree
    logic [2:0] pin_raw;
    logic [2:0] pin_q;

    assign pin_raw = {low_battery_input, polarity_input_b, polarity_input_a};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_pin
            logic [2:0] sync_q;
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    sync_q <= 3'b000;
                end
                else
                begin
                    sync_q <= {sync_q[1:0], pin_raw[gi]};
                end
            end
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    pin_q[gi] <= 1'b0;
                end
                else if (sync_q[1] == sync_q[2])
                begin
                    pin_q[gi] <= sync_q[2];
                end
            end
        end
    endgenerate

    logic pol_a_prev_q;
    logic pol_b_prev_q;
    logic pol_a_rise;
    logic pol_b_rise;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pol_a_prev_q <= 1'b0;
            pol_b_prev_q <= 1'b0;
        end
        else
        begin
            pol_a_prev_q <= pin_q[0];
            pol_b_prev_q <= pin_q[1];
        end
    end

    assign pol_a_rise = pin_q[0] && !pol_a_prev_q;
    assign pol_b_rise = pin_q[1] && !pol_b_prev_q;

    // Mode registers
    logic [7:0] mode_a_q;
    logic [7:0] mode_b_q;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_a_q <= MODE_A_RESET;
        end
        else if (do_write && link_req_q.addr == ADDR_MODE_A)
        begin
            mode_a_q <= link_req_q.wdata & MODE_A_MASK;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_b_q <= MODE_B_RESET;
        end
        else if (do_write && link_req_q.addr == ADDR_MODE_B)
        begin
            mode_b_q <= link_req_q.wdata & MODE_B_MASK;
        end
    end

    // Sticky FSK flags; a new overrun or framing event wins over a read clear in the same cycle
    logic mark_q;
    logic overrun_q;
    logic framing_q;
    logic status_read;

    assign status_read = do_read && link_req_q.addr == ADDR_LINE_STATUS;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mark_q <= 1'b0;
        end
        else if (mark_start_event && mode_a_q[MDA_FSK_EN])
        begin
            mark_q <= 1'b1;
        end
        else if (!mode_a_q[MDA_FSK_EN])
        begin
            mark_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            overrun_q <= 1'b0;
        end
        else if (fsk_overrun_event)
        begin
            overrun_q <= 1'b1;
        end
        else if (status_read)
        begin
            overrun_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            framing_q <= 1'b0;
        end
        else if (fsk_framing_event)
        begin
            framing_q <= 1'b1;
        end
        else if (status_read)
        begin
            framing_q <= 1'b0;
        end
    end

    // Ring period measurement in coarse ticks, saturating
    logic [31:0] tick_cnt_q;
    logic tick;
    logic [7:0] ring_cnt_q;
    logic ring_armed_q;
    logic b_seen_q;
    logic [7:0] ring_period_q;

    assign tick = tick_cnt_q == RING_TICK - 1;

    always_ff @(posedge clk_sys)
    begin
        if (rst || pol_a_rise || tick)
        begin
            tick_cnt_q <= '0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || pol_a_rise)
        begin
            ring_cnt_q <= BYTE_ZERO;
        end
        else if (tick && ring_cnt_q != RING_MAX)
        begin
            ring_cnt_q <= ring_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ring_armed_q <= 1'b0;
            b_seen_q <= 1'b0;
            ring_period_q <= BYTE_ZERO;
        end
        else if (pol_a_rise)
        begin
            ring_armed_q <= 1'b1;
            b_seen_q <= 1'b0;
            if (ring_armed_q && (b_seen_q || pol_b_rise))
            begin
                ring_period_q <= ring_cnt_q;
            end
        end
        else if (pol_b_rise)
        begin
            b_seen_q <= 1'b1;
        end
    end

    // Read data back to the link side
    logic [7:0] status_byte;

    always_comb
    begin
        status_byte = BYTE_ZERO;
        status_byte[STA_POL_A] = pin_q[0];
        status_byte[STA_POL_B] = ~pin_q[1];
        status_byte[STA_LOW_BAT] = ~pin_q[2];
        status_byte[STA_MARK] = mark_q;
        status_byte[STA_OVERRUN] = overrun_q;
        status_byte[STA_FRAMING] = framing_q;
    end

    // Writes to status and ring period fall through unchanged
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sys_rdata_q <= BYTE_ZERO;
            ack_tgl_q <= 1'b0;
        end
        else if (req_seen)
        begin
            ack_tgl_q <= ~ack_tgl_q;
            unique case (link_req_q.addr)
                ADDR_LINE_STATUS: sys_rdata_q <= status_byte;
                ADDR_RING_PERIOD: sys_rdata_q <= ring_period_q;
                ADDR_MODE_A: sys_rdata_q <= mode_a_q;
                ADDR_MODE_B: sys_rdata_q <= mode_b_q;
                default: sys_rdata_q <= UNMAPPED_READ;
            endcase
        end
    end

    // Decoded controls; oscillator order is left to the host
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_q <= '0;
            fsk_byte_irq_pass_q <= 1'b0;
            timebase_irq_pass_q <= 1'b0;
        end
        else
        begin
            mode_q.fsk_receiver_enable <= mode_a_q[MDA_FSK_EN];
            mode_q.mark_start_irq_gate <= mode_a_q[MDA_MARK_GATE];
            mode_q.alert_detector_enable <= mode_a_q[MDA_ALERT_EN];
            mode_q.polarity_irq_enable <= mode_a_q[MDA_POL_IRQ_EN];
            mode_q.irq_active_high <= mode_a_q[MDA_IRQ_HIGH];
            mode_q.main_osc_enable <= mode_b_q[MDB_OSC_EN];
            mode_q.timebase_enable <= mode_b_q[MDB_TB_EN];
            mode_q.timebase_period_select <= mode_b_q[MDB_TB_SECOND];
            mode_q.timebase_irq_suppress <= mode_b_q[MDB_TB_SUPPRESS];
            fsk_byte_irq_pass_q <= mode_a_q[MDA_FSK_EN]
                && (!mode_a_q[MDA_MARK_GATE] || mark_q);
            // Gates the pin only; the flag keeps recording the event
            timebase_irq_pass_q <= !(mode_b_q[MDB_TB_SUPPRESS]
                && mode_a_q[MDA_FSK_EN] && fsk_receiving);
        end
    end

endmodule

// >>> verification/cid_host_model.sv
// Serial engine stand-in issuing register requests on the link clock
`timescale 1ns/1ps
module cid_host_model (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic link_rst,
    // Register port
    output logic req_valid,
    output cid_regs_pkg::reg_req_t req,
    input wire logic req_ready_q,
    input wire logic rsp_valid_q,
    input wire logic [7:0] rd_data_q
);
    import cid_regs_pkg::*;
    logic timed_out;
    initial
    begin
        req_valid = 1'b0;
        req = '0;
        timed_out = 1'b0;
    end
    // One outstanding request; gap sets prompt or slow issue
    task automatic access(input logic [7:0] addr, input logic wr,
        input logic [7:0] wdata, input int gap, output logic [7:0] rdata);
        int n;
        n = 0;
        repeat (gap) @(posedge link_clk);
        req_valid <= 1'b1;
        req <= '{addr: addr, write: wr, wdata: wdata};
        do
        begin
            @(posedge link_clk);
            n++;
        end
        while (!req_ready_q && n < 40);
        // Idle bus shows the inverse so stale values never match
        req_valid <= 1'b0;
        req <= reg_req_t'(~req);
        do
        begin
            @(posedge link_clk);
            n++;
        end
        while (!rsp_valid_q && n < 80);
        timed_out = timed_out | !rsp_valid_q;
        rdata = rd_data_q;
    endtask
endmodule

// >>> verification/cid_status_mode_regs_bench.sv
// Self-checking bench for the status, ring period and mode registers
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    bad_count++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end end
module cid_status_mode_regs_bench;
    import cid_regs_pkg::*;
    localparam int unsigned TICK = 4;
    logic clk_sys, rst, link_clk, link_rst, req_valid, req_ready_q;
    logic rsp_valid_q, pol_a, pol_b, low_bat, mark_ev, ovr_ev, frm_ev;
    logic fsk_rx, byte_pass, tb_pass;
    logic [7:0] rd_data_q, q, d, a, mda, mdb, last;
    reg_req_t req;
    mode_ctrl_t mode_q;
    int bad_count, tests_run, rp, e;
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    cid_status_mode_regs #(.RING_TICK(TICK)) cid_status_mode_regs_i (
        .clk_sys(clk_sys), .rst(rst), .link_clk(link_clk),
        .link_rst(link_rst), .req_valid(req_valid), .req(req),
        .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
        .rd_data_q(rd_data_q), .polarity_input_a(pol_a),
        .polarity_input_b(pol_b), .low_battery_input(low_bat),
        .mark_start_event(mark_ev), .fsk_overrun_event(ovr_ev),
        .fsk_framing_event(frm_ev), .fsk_receiving(fsk_rx),
        .mode_q(mode_q), .fsk_byte_irq_pass_q(byte_pass),
        .timebase_irq_pass_q(tb_pass));
    cid_host_model cid_host_model_i (
        .link_clk(link_clk), .link_rst(link_rst), .req_valid(req_valid),
        .req(req), .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
        .rd_data_q(rd_data_q));
    function automatic mode_ctrl_t exp_mode(logic [7:0] ma, logic [7:0] mb);
        return mode_ctrl_t'({ma[7:3], mb[7:4]});
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic acc(input logic [7:0] ad, input logic w,
        input logic [7:0] v);
        cid_host_model_i.access(ad, w, v, 1 + $urandom_range(3), q);
        if (cid_host_model_i.timed_out)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task automatic sys(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Pin A rises twice, p edges apart; B rises between only if asked
    task automatic ring(input logic with_b, input int p);
        sys(1);
        pol_a <= 1'b0;
        pol_b <= 1'b0;
        sys(10);
        pol_a <= 1'b1;
        sys(10);
        pol_b <= with_b;
        sys(10);
        pol_a <= 1'b0;
        pol_b <= 1'b0;
        sys(p - 20);
        pol_a <= 1'b1;
        sys(10);
        acc(ADDR_RING_PERIOD, 1'b0, 8'h00);
    endtask
    initial
    begin
        {rst, link_rst, pol_a, pol_b, low_bat} = 5'b1_1001;
        {mark_ev, ovr_ev, frm_ev, fsk_rx} = 4'h0;
        bad_count = 0;
        tests_run = 0;
        void'($urandom(3));
        sys(10);
        rst <= 1'b0;
        link_rst <= 1'b0;
        mda = 8'h58;
        mdb = 8'hD0;
        for (int i = 0; i < 6; i++)
        begin
            a = (i < 2) ? 8'(i) : 8'($urandom_range(255, 6));
            acc(a, 1'b0, 8'h00);
            `CHK(q, 8'hFF)
            acc(8'(i % 4), 1'b1, 8'($urandom));
        end
        $display("map test done");
        for (int i = 0; i < 8; i++)
        begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            // Oscillator stays on ahead of receiver writes
            acc(ADDR_MODE_B, 1'b1, d | 8'h80);
            `CHK(q, mdb)
            mdb = (d | 8'h80) & 8'hF0;
            acc(ADDR_MODE_A, 1'b1, ~d);
            `CHK(q, mda)
            mda = ~d & 8'hF8;
            sys(4);
            `CHK(mode_q, exp_mode(mda, mdb))
            acc(ADDR_MODE_A, 1'b0, 8'h00);
            `CHK(q, mda)
            acc(ADDR_MODE_B, 1'b0, 8'h00);
            `CHK(q, mdb)
        end
        $display("mode test done");
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_sys);
            {pol_a, pol_b, low_bat} <= (i == 0) ? 3'b101 : 3'($urandom);
            sys(8);
            acc(ADDR_LINE_STATUS, 1'b0, 8'h00);
            d = {pol_a, ~pol_b, ~low_bat, 5'h00};
            `CHK(q, d)
        end
        acc(ADDR_MODE_B, 1'b1, 8'hD0);
        acc(ADDR_MODE_A, 1'b1, 8'h80);
        sys(4);
        `CHK(byte_pass, 1'b1)
        acc(ADDR_MODE_A, 1'b1, 8'hC0);
        sys(4);
        `CHK(byte_pass, 1'b0)
        {mark_ev, ovr_ev, frm_ev} <= 3'h7;
        sys(1);
        {mark_ev, ovr_ev, frm_ev} <= 3'h0;
        sys(4);
        `CHK(byte_pass, 1'b1)
        acc(ADDR_LINE_STATUS, 1'b0, 8'h00);
        `CHK(q[4:0], 5'h1C)
        acc(ADDR_LINE_STATUS, 1'b0, 8'h00);
        `CHK(q[4:2], 3'b100)
        fsk_rx <= 1'b1;
        sys(4);
        `CHK(tb_pass, 1'b0)
        fsk_rx <= 1'b0;
        sys(4);
        `CHK(tb_pass, 1'b1)
        $display("status test done");
        for (int i = 0; i < 3; i++)
        begin
            rp = (i == 2) ? 1200 : 40 + $urandom_range(200);
            ring(1'b1, rp);
            e = (rp / TICK > 255) ? 255 : rp / TICK;
            `CHK(int'(q) >= e - 1 && int'(q) <= e + 1, 1'b1)
        end
        last = q;
        ring(1'b0, 100);
        `CHK(q, last)
        $display("ring test done");
        report_and_stop();
    end
endmodule
bind cid_status_mode_regs cid_status_mode_regs_sva cid_status_mode_regs_sva_i (
    .clk_sys(clk_sys), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
    .req_valid(req_valid), .req_ready_q(req_ready_q),
    .rsp_valid_q(rsp_valid_q), .fsk_receiving(fsk_receiving),
    .mode_q(mode_q), .fsk_byte_irq_pass_q(fsk_byte_irq_pass_q),
    .timebase_irq_pass_q(timebase_irq_pass_q));

// >>> verification/cid_status_mode_regs_sva.sv
// Port assertions for the status, ring period and mode register block
`timescale 1ns/1ps
module cid_status_mode_regs_sva (
    // Clocks and resets
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_rst,
    // Register port
    input wire logic req_valid,
    input wire logic req_ready_q,
    input wire logic rsp_valid_q,
    // Mode outputs and gating
    input wire logic fsk_receiving,
    input wire cid_regs_pkg::mode_ctrl_t mode_q,
    input wire logic fsk_byte_irq_pass_q,
    input wire logic timebase_irq_pass_q
);
    import cid_regs_pkg::*;
    sequence s_take;
        req_valid && req_ready_q;
    endsequence
    sequence s_fsk_off;
        !mode_q.fsk_receiver_enable [*2];
    endsequence
    sequence s_byte_open;
        (mode_q.fsk_receiver_enable && !mode_q.mark_start_irq_gate) [*2];
    endsequence
    // Three cycles allow for the registered pass and mode outputs
    sequence s_tb_held;
        (mode_q.fsk_receiver_enable && mode_q.timebase_irq_suppress
            && fsk_receiving) [*3];
    endsequence
    sequence s_tb_free;
        (!mode_q.fsk_receiver_enable || !mode_q.timebase_irq_suppress
            || !fsk_receiving) [*3];
    endsequence
    a_reset_modes: assert property (
        @(posedge clk_sys) disable iff (rst)
        $fell(rst) |=> mode_q == 9'h0BD)
        else $error("mode outputs wrong after reset");
    a_byte_irq_off: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_fsk_off |-> !fsk_byte_irq_pass_q)
        else $error("byte interrupt open with receiver off");
    a_byte_irq_open: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_byte_open |-> fsk_byte_irq_pass_q)
        else $error("byte interrupt closed with gate off");
    a_tb_suppressed: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_tb_held |-> !timebase_irq_pass_q)
        else $error("timebase passes during reception");
    a_tb_passes: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_tb_free |-> timebase_irq_pass_q)
        else $error("timebase blocked without suppression");
    a_take_drops: assert property (
        @(posedge link_clk) disable iff (link_rst)
        s_take |=> !req_ready_q)
        else $error("ready stayed high after take");
    a_rsp_bounded: assert property (
        @(posedge link_clk) disable iff (link_rst)
        s_take |-> ##[2:40] rsp_valid_q)
        else $error("no response to request");
    a_rsp_single: assert property (
        @(posedge link_clk) disable iff (link_rst)
        rsp_valid_q |=> !rsp_valid_q)
        else $error("response longer than one cycle");
    a_rsp_ready: assert property (
        @(posedge link_clk) disable iff (link_rst)
        rsp_valid_q |-> req_ready_q)
        else $error("ready low at response");
endmodule
